// file: hw/hsc_top.sv
// Hardware standby sequencer: pin driven entry, oscillator restart, reset sequence
`timescale 1ns/10ps
`include "hsc_cfg.svh"
module hsc_top (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_standby_request_n,
    input  wire logic       i_external_reset_n,
    input  wire logic       i_mode_select_hi,
    input  wire logic       i_mode_select_lo,
    input  wire logic       i_irq,
    output logic            o_cpu_halt,
    output logic            o_periph_clear,
    output logic            o_io_float,
    output logic            o_osc_enable,
    output logic            o_prog_mode,
    output logic            o_ram_write_block,
    output logic            o_irq_accept,
    output logic            o_in_standby
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        hsc_pkg::hsc_state_t                 fsm;
        logic [`HSC_RESET_SEQ_W-1:0]         cnt;
        logic                                ram_blk;
        logic                                irq_acc;
        logic                                standby_request_n;
    } hsc_top_t;

    hsc_top_t st_reg;
    hsc_top_t st_next;

    hsc_ctrl_if ctrl ();

    logic in_low_power;
    logic mode_prog;

    assign mode_prog = ({i_mode_select_hi, i_mode_select_lo} == `HSC_MODE_PROG);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        st_next         = st_reg;
        st_next.irq_acc = 1'b0;
        case (st_reg.fsm)
            hsc_pkg::HSC_RUN: begin
                if (!i_external_reset_n) begin
                    st_next.fsm = hsc_pkg::HSC_HELDRST;
                end else begin
                    st_next.irq_acc = i_irq;
                end
            end
            hsc_pkg::HSC_HELDRST: begin
                if (i_external_reset_n) begin
                    st_next.fsm = hsc_pkg::HSC_RESSEQ;
                    st_next.cnt = '0;
                end
            end
            hsc_pkg::HSC_STANDBY: begin
                // Oscillator restarts only once the request is released
                if (i_standby_request_n) begin
                    st_next.fsm = hsc_pkg::HSC_WAKE;
                end
            end
            hsc_pkg::HSC_WAKE: begin
                // Leaves for the reset sequence as soon as i_external_reset_n is high, so release with reset high resumes execution
                if (i_external_reset_n) begin
                    st_next.fsm = hsc_pkg::HSC_RESSEQ;
                    st_next.cnt = '0;
                end
            end
            hsc_pkg::HSC_RESSEQ: begin
                if (!i_external_reset_n) begin
                    st_next.fsm = hsc_pkg::HSC_HELDRST;
                end else if (st_reg.cnt == `HSC_RESET_SEQ_CYCLES - 8'h01) begin
                    st_next.fsm = hsc_pkg::HSC_RUN;
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            default: begin
                st_next.fsm = hsc_pkg::HSC_HELDRST;
            end
        endcase
        // Request low wins over every state, sleep or otherwise
        if (!i_standby_request_n) begin
            st_next.fsm     = hsc_pkg::HSC_STANDBY;
            st_next.irq_acc = 1'b0;
        end
        st_next.standby_request_n    = (st_next.fsm == hsc_pkg::HSC_STANDBY);
        // Block RAM writes so contents survive the power-down
        st_next.ram_blk = (st_next.fsm != hsc_pkg::HSC_RUN);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{fsm: hsc_pkg::HSC_HELDRST, cnt: '0, ram_blk: 1'b1,
                        irq_acc: 1'b0, standby_request_n: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    assign in_low_power = (st_next.fsm == hsc_pkg::HSC_STANDBY);

    assign ctrl.halt         = (st_next.fsm != hsc_pkg::HSC_RUN);
    assign ctrl.clear_periph = (st_next.fsm != hsc_pkg::HSC_RUN);
    assign ctrl.float_io     = in_low_power;
    // Oscillator stops only while the request is held low
    assign ctrl.osc_run      = !in_low_power;
    // Mode pins are not latched: a change in standby reaches o_prog_mode on the next clock
    assign ctrl.prog_mode    = in_low_power && mode_prog;

    hsc_out_stage u_out (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .ctrl           (ctrl),
        .o_cpu_halt     (o_cpu_halt),
        .o_periph_clear (o_periph_clear),
        .o_io_float     (o_io_float),
        .o_osc_enable   (o_osc_enable),
        .o_prog_mode    (o_prog_mode)
    );

    assign o_ram_write_block = st_reg.ram_blk;
    assign o_irq_accept      = st_reg.irq_acc;
    assign o_in_standby      = st_reg.standby_request_n;
endmodule : hsc_top

// file: hw/hsc_cfg.svh
// Constants of the hardware standby controller
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH
// Reset sequence length in clock cycles after reset release
`define HSC_RESET_SEQ_CYCLES 8'h10
`define HSC_RESET_SEQ_W      8
// Mode pin code that selects programmer mode
`define HSC_MODE_PROG        2'h0
`endif

// file: hw/hsc_pkg.sv
// Types of the hardware standby controller
package hsc_pkg;
    typedef enum logic [2:0] {
        HSC_RUN     = 3'b000,
        HSC_STANDBY = 3'b001,
        HSC_WAKE    = 3'b010,
        HSC_RESSEQ  = 3'b011,
        HSC_HELDRST = 3'b100
    } hsc_state_t;
endpackage : hsc_pkg

// file: hw/hsc_ctrl_if.sv
// Control bundle between the sequencer and its output stage
`timescale 1ns/10ps
interface hsc_ctrl_if;
    logic halt;
    logic clear_periph;
    logic float_io;
    logic osc_run;
    logic prog_mode;
    modport seq (output halt, output clear_periph, output float_io, output osc_run,
                 output prog_mode);
    modport outs (input halt, input clear_periph, input float_io, input osc_run,
                  input prog_mode);
endinterface : hsc_ctrl_if

// file: hw/hsc_out_stage.sv
// Registered output stage of the hardware standby controller
`timescale 1ns/10ps
module hsc_out_stage (
    input  wire logic i_clk,
    input  wire logic i_rst,
    hsc_ctrl_if.outs  ctrl,
    output logic      o_cpu_halt,
    output logic      o_periph_clear,
    output logic      o_io_float,
    output logic      o_osc_enable,
    output logic      o_prog_mode
);
    typedef struct packed {
        logic halt;
        logic clr;
        logic flt;
        logic osc;
        logic prog;
    } hsc_out_t;

    hsc_out_t st_reg;
    hsc_out_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.halt = ctrl.halt;
        st_next.clr  = ctrl.clear_periph;
        st_next.flt  = ctrl.float_io;
        st_next.osc  = ctrl.osc_run;
        st_next.prog = ctrl.prog_mode;
    end

    // Safe values at reset: halted, cleared, floating, oscillator on
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{halt: 1'b1, clr: 1'b1, flt: 1'b1, osc: 1'b1, prog: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_cpu_halt     = st_reg.halt;
    assign o_periph_clear = st_reg.clr;
    assign o_io_float     = st_reg.flt;
    assign o_osc_enable   = st_reg.osc;
    assign o_prog_mode    = st_reg.prog;
endmodule : hsc_out_stage

// file: tb/hsc_sva.sv
// Port assertions of the hardware standby sequencer
`timescale 1ns/10ps
module hsc_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_standby_request_n,
    input wire logic i_external_reset_n,
    input wire logic i_mode_select_hi,
    input wire logic i_mode_select_lo,
    input wire logic o_cpu_halt,
    input wire logic o_periph_clear,
    input wire logic o_io_float,
    input wire logic o_osc_enable,
    input wire logic o_prog_mode,
    input wire logic o_ram_write_block,
    input wire logic o_irq_accept,
    input wire logic o_in_standby
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_wake;
        $rose(i_external_reset_n) && i_standby_request_n && o_cpu_halt;
    endsequence
    sequence s_release;
        ##16 o_cpu_halt ##1 !o_cpu_halt;
    endsequence
    AST_ENTER: assert property (!i_standby_request_n |=> o_in_standby && o_io_float
        && !o_osc_enable && o_cpu_halt) else $error("standby entry outputs wrong");
    AST_HOLD: assert property (o_in_standby |-> o_periph_clear && o_ram_write_block)
        else $error("standby without clear or ram block");
    AST_PROG: assert property (!i_standby_request_n && !i_mode_select_hi
        && !i_mode_select_lo |=> o_prog_mode) else $error("programmer mode missing");
    AST_NOPROG: assert property (i_standby_request_n |=> !o_prog_mode)
        else $error("programmer mode outside standby");
    AST_WAKE: assert property ($rose(i_standby_request_n) && !i_external_reset_n
        |=> o_cpu_halt && o_osc_enable && !o_io_float) else $error("wake outputs wrong");
    AST_IRQ: assert property (!i_standby_request_n |=> !o_irq_accept)
        else $error("irq accepted in standby");
    AST_RESSEQ: assert property (s_wake |-> s_release)
        else $error("reset sequence length wrong");
    AST_RSTRUN: assert property (!o_cpu_halt && !i_external_reset_n |=> o_cpu_halt)
        else $error("reset low did not halt");
endmodule : hsc_sva
bind hsc_top hsc_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
    .i_standby_request_n(i_standby_request_n), .i_external_reset_n(i_external_reset_n),
    .i_mode_select_hi(i_mode_select_hi), .i_mode_select_lo(i_mode_select_lo),
    .o_cpu_halt(o_cpu_halt), .o_periph_clear(o_periph_clear), .o_io_float(o_io_float),
    .o_osc_enable(o_osc_enable), .o_prog_mode(o_prog_mode),
    .o_ram_write_block(o_ram_write_block), .o_irq_accept(o_irq_accept),
    .o_in_standby(o_in_standby));

// file: tb/hsc_ctl_model.sv
// External system controller driving the standby and reset pins
`timescale 1ns/10ps
module hsc_ctl_model #(parameter int SETTLE = 20) (
    input  wire logic i_clk,
    input  wire logic i_sleep,
    output logic      o_standby_request_n,
    output logic      o_external_reset_n
);
    int cnt;
    initial begin
        o_standby_request_n = 1'b1;
        o_external_reset_n  = 1'b0;
        cnt                 = 0;
    end
    // Settling is counted here, the device has no timer of its own
    always @(posedge i_clk) begin
        if (i_sleep) begin
            cnt <= 0;
            if (o_external_reset_n) o_external_reset_n <= 1'b0;
            else o_standby_request_n <= 1'b0;
        end else if (!o_standby_request_n) o_standby_request_n <= 1'b1;
        else if (cnt < SETTLE) cnt <= cnt + 1;
        else o_external_reset_n <= 1'b1;
    end
endmodule : hsc_ctl_model

// file: tb/testbench.sv
// Self-checking bench of the hardware standby sequencer
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, sleep = 1'b0, irq = 1'b0, mhi = 1'b1, mlo = 1'b1;
    logic standby_request_n_n, res_n, halt, clr, flt, osc, prog, ramb, irqa, insb;
    int   err_total = 0, tests_run = 0, cyc = 0;
    always #4 clk = ~clk;
    hsc_ctl_model u_ctl (.i_clk(clk), .i_sleep(sleep), .o_standby_request_n(standby_request_n_n),
        .o_external_reset_n(res_n));
    hsc_top uut (.i_clk(clk), .i_rst(rst), .i_standby_request_n(standby_request_n_n),
        .i_external_reset_n(res_n), .i_mode_select_hi(mhi), .i_mode_select_lo(mlo),
        .i_irq(irq), .o_cpu_halt(halt), .o_periph_clear(clr), .o_io_float(flt),
        .o_osc_enable(osc), .o_prog_mode(prog), .o_ram_write_block(ramb),
        .o_irq_accept(irqa), .o_in_standby(insb));
    task automatic check(input string name, input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic run_wait;
        for (int i = 0; i < 100 && halt !== 1'b0; i++) @(posedge clk);
        #1 check("halt", halt, 1'b0);
        check("ram_block", ramb, 1'b0);
        check("clear", clr, 1'b0);
        check("float", flt, 1'b0);
        @(posedge clk);
        irq <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("irq_accept", irqa, 1'b1);
        irq <= 1'b0;
    endtask : run_wait
    task automatic t_standby(input logic hi, input logic lo);
        @(posedge clk);
        mhi <= hi;
        mlo <= lo;
        sleep <= 1'b1;
        irq <= 1'b1;
        for (int i = 0; i < 10 && insb !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1 check("float", flt, 1'b1);
        check("osc", osc, 1'b0);
        check("clear", clr, 1'b1);
        check("ram_block", ramb, 1'b1);
        check("prog", prog, ~hi & ~lo);
        check("irq_accept", irqa, 1'b0);
        @(posedge clk);
        sleep <= 1'b0;
        irq <= 1'b0;
        for (int i = 0; i < 10 && osc !== 1'b1; i++) @(posedge clk);
        #1 check("osc", osc, 1'b1);
        check("halt", halt, 1'b1);
        check("in_standby", insb, 1'b0);
        check("prog", prog, 1'b0);
        run_wait();
    endtask : t_standby
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        run_wait();
        t_standby(1'b1, 1'b1);
        t_standby(1'b0, 1'b1);
        t_standby(1'b0, 1'b0);
        give_verdict();
    end
endmodule : testbench
